/* File: shared/chopper_step_pkg.sv */
// Purpose: constants for the step/direction and chopper configuration block
// Assumes: 20-bit serial words, most significant bit shifted in first
// Notes:   all counts are in system clock periods

package chopper_step_pkg;

   // ****************************************
   // word framing and select codes
   // ****************************************
   localparam int         WORD_W        = 20;
   localparam logic [5:0] WORD_BITS     = 6'h14;
   localparam logic [1:0] SEL_PULSE_DIR = 2'h0;   // bits 19:18
   localparam logic [2:0] SEL_CHOPPER   = 3'h4;   // bits 19:17

   // ****************************************
   // field positions
   // ****************************************
   localparam int PULSE_INTERPOLATION_ENABLE_BIT = 9;
   localparam int DOUBLE_EDGE_ENABLE_BIT  = 8;
   localparam int MICROSTEP_RESOLUTION_LSB   = 0;
   localparam int TBL_LSB    = 15;
   localparam int CHM_BIT    = 14;
   localparam int RANDOM_OFF_TIME_BIT  = 13;
   localparam int TIMER_ONLY_FAST_DECAY_BIT  = 12;
   localparam int FAST_DECAY_MSB_BIT  = 11;
   localparam int HYSTERESIS_END_OR_SINE_OFFSET_LSB   = 7;
   localparam int HYSTERESIS_START_OR_FAST_DECAY_TIME_LSB  = 4;
   localparam int TOFF_LSB   = 0;

   // ****************************************
   // values after reset
   // ****************************************
   localparam logic [19:0] PULSE_DIR_RESET = 20'h00000;
   localparam logic [19:0] CHOPPER_RESET   = 20'h00000;
   localparam logic [3:0]  LFSR_SEED       = 4'h9;

   // ****************************************
   // cycle counts
   // ****************************************
   localparam logic [5:0] BLANK_CODE0_CLK = 6'h10;  // 16
   localparam logic [5:0] BLANK_CODE1_CLK = 6'h18;  // 24
   localparam logic [5:0] BLANK_CODE2_CLK = 6'h24;  // 36
   localparam logic [5:0] BLANK_CODE3_CLK = 6'h36;  // 54
   localparam logic [6:0] HYSTERESIS_DECREMENT_UNIT_CLK   = 7'h10;  // 16 per code step
   localparam logic [8:0] FAST_UNIT_CLK   = 9'h020; // 32
   localparam logic [9:0] SLOW_BASE_CLK   = 10'h018; // 24
   localparam logic [9:0] SLOW_UNIT_CLK   = 10'h020; // 32
   localparam logic [9:0] RANDOM_BIAS_CLK = 10'h00c; // spread -11..+3
   localparam logic [4:0] INTERP_STEPS    = 5'h10;  // 16
   localparam logic [3:0] INTERP_GAP_CLK  = 4'h8;
   localparam logic [3:0] MICROSTEP_RESOLUTION_MAX        = 4'h8;
   localparam logic [5:0] HYST_BIAS       = 6'h03;

   // ****************************************
   // bridge phases
   // ****************************************
   typedef enum logic [1:0]
   {
      PH_OFF  = 2'b00,
      PH_ON   = 2'b01,
      PH_FAST = 2'b10,
      PH_SLOW = 2'b11
   } phase_type;

endpackage

/* File: logic/chopper_and_step_config.sv */
// Purpose: serial configuration words, step input and chopper sequencing
// Assumes: all inputs synchronous to clock; serial clock far below clock
// Notes:   bridge_phase tells the power stage which switches are on

// ****************************************
// top module
// ****************************************
module chopper_and_step_config
   import chopper_step_pkg::*;
(
   // clock and reset
   input  wire logic        clock,
   input  wire logic        rst_b,
   // serial port
   input  wire logic        spi_cs_b,
   input  wire logic        spi_sck,
   input  wire logic        spi_mosi,
   // step and direction
   input  wire logic        step_pulse,
   input  wire logic        step_direction,
   input  wire logic        serial_only_mode,
   // current comparators
   input  wire logic        coil_current_reached,
   input  wire logic        coil_negative_reached,
   // outputs
   output logic [9:0]       microstep_position,
   output logic [1:0]       bridge_phase,
   output logic             driver_enable,
   output logic signed [5:0] current_offset,
   output logic [19:0]      pulse_direction_config,
   output logic [19:0]      chopper_config
);

   typedef struct packed
   {
      logic [19:0] pdc;
      logic [19:0] chc;
      logic [19:0] shift;
      logic [5:0]  bitcnt;
      logic        sck_q;
      logic        cs_q;
      logic        step_q;
      logic [9:0]  pos;
      logic [4:0]  interp_left;
      logic [3:0]  interp_gap;
      logic        interp_dir;
      phase_type   phase;
      logic [9:0]  timer;
      logic [5:0]  blank;
      logic [4:0]  hyst;
      logic [6:0]  hysteresis_decrement_cnt;
      logic [3:0]  lfsr;
      logic [5:0]  offset;
   } state_type;

   state_type state;
   state_type next_state;

   // ****************************************
   // field decode
   // ****************************************
   logic       pulse_interpolation_enable;
   logic       double_edge_enable;
   logic [3:0] microstep_resolution;
   logic [1:0] blanking_time;
   logic       chopper_mode;
   logic       random_off_time;
   logic [1:0] hysteresis_decrement;
   logic       fast_decay_msb;
   logic       timer_only_fast_decay;
   logic [3:0] hysteresis_end_or_sine_offset;
   logic [2:0] hysteresis_start_or_fast_decay_time;
   logic [3:0] off_time;

   assign pulse_interpolation_enable = state.pdc[PULSE_INTERPOLATION_ENABLE_BIT];
   assign double_edge_enable         = state.pdc[DOUBLE_EDGE_ENABLE_BIT];
   assign microstep_resolution       = state.pdc[MICROSTEP_RESOLUTION_LSB +: 4];
   assign blanking_time              = state.chc[TBL_LSB +: 2];
   assign chopper_mode               = state.chc[CHM_BIT];
   assign random_off_time            = state.chc[RANDOM_OFF_TIME_BIT];
   assign hysteresis_decrement       = state.chc[FAST_DECAY_MSB_BIT +: 2];
   assign fast_decay_msb             = state.chc[FAST_DECAY_MSB_BIT];
   assign timer_only_fast_decay      = state.chc[TIMER_ONLY_FAST_DECAY_BIT];
   assign hysteresis_end_or_sine_offset       = state.chc[HYSTERESIS_END_OR_SINE_OFFSET_LSB +: 4];
   assign hysteresis_start_or_fast_decay_time = state.chc[HYSTERESIS_START_OR_FAST_DECAY_TIME_LSB +: 3];
   assign off_time                   = state.chc[TOFF_LSB +: 4];

   // ****************************************
   // derived lengths
   // ****************************************
   logic        word_commit;
   logic        step_event;
   logic [3:0]  microstep_resolution_eff;
   logic [9:0]  step_inc;
   logic [9:0]  sub_inc;
   logic [5:0]  blank_len;
   logic [6:0]  hysteresis_decrement_len;
   logic [8:0]  fast_len;
   logic [9:0]  slow_len;
   logic [9:0]  random_adj;
   logic [4:0]  hyst_start;

   assign word_commit = spi_cs_b && !state.cs_q && (state.bitcnt >= WORD_BITS);
   assign step_event  = !serial_only_mode &&
      ((step_pulse && !state.step_q) ||
       (double_edge_enable && !step_pulse && state.step_q));
   assign microstep_resolution_eff = (microstep_resolution > MICROSTEP_RESOLUTION_MAX) ? MICROSTEP_RESOLUTION_MAX
                                                       : microstep_resolution;
   assign step_inc = 10'h001 << microstep_resolution_eff;
   assign sub_inc  = (step_inc[9:4] == 6'h00) ? 10'h001
                                              : {4'h0, step_inc[9:4]};

   always_comb
   begin
      case (blanking_time)
         2'h0:    blank_len = BLANK_CODE0_CLK;
         2'h1:    blank_len = BLANK_CODE1_CLK;
         2'h2:    blank_len = BLANK_CODE2_CLK;
         default: blank_len = BLANK_CODE3_CLK;
      endcase
   end

   assign hysteresis_decrement_len   = 7'(hysteresis_decrement) * HYSTERESIS_DECREMENT_UNIT_CLK
                       + HYSTERESIS_DECREMENT_UNIT_CLK;
   assign fast_len   = 9'({fast_decay_msb,
                           hysteresis_start_or_fast_decay_time})
                       * FAST_UNIT_CLK;
   assign random_adj = random_off_time ? 10'(state.lfsr) - RANDOM_BIAS_CLK
                                       : 10'h000;
   assign slow_len   = SLOW_BASE_CLK + 10'(off_time) * SLOW_UNIT_CLK
                       + random_adj;
   assign hyst_start = 5'(hysteresis_end_or_sine_offset)
                       + 5'(hysteresis_start_or_fast_decay_time)
                       + 5'h01;

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      next_state = state;
      next_state.sck_q  = spi_sck;
      next_state.cs_q   = spi_cs_b;
      next_state.step_q = step_pulse;
      next_state.lfsr   = {state.lfsr[2:0], state.lfsr[3] ^ state.lfsr[2]};

      // serial word capture
      if (spi_cs_b)
         next_state.bitcnt = 6'h00;
      else if (spi_sck && !state.sck_q)
      begin
         next_state.shift = {state.shift[WORD_W-2:0], spi_mosi};
         if (state.bitcnt < WORD_BITS)
            next_state.bitcnt = state.bitcnt + 6'h01;
      end
      if (word_commit)
      begin
         if (state.shift[19:18] == SEL_PULSE_DIR && !serial_only_mode)
            next_state.pdc = state.shift;
         else if (state.shift[19:17] == SEL_CHOPPER)
            next_state.chc = state.shift;
      end

      // step position and interpolation
      if (step_event && pulse_interpolation_enable)
      begin
         next_state.interp_left = INTERP_STEPS;
         next_state.interp_gap  = 4'h0;
         next_state.interp_dir  = step_direction;
      end
      else if (step_event)
         next_state.pos = step_direction ? state.pos - step_inc
                                         : state.pos + step_inc;
      else if (state.interp_left != 5'h00)
      begin
         if (state.interp_gap == 4'h0)
         begin
            next_state.pos = state.interp_dir ? state.pos - sub_inc
                                              : state.pos + sub_inc;
            next_state.interp_left = state.interp_left - 5'h01;
            next_state.interp_gap  = INTERP_GAP_CLK - 4'h1;
         end
         else
            next_state.interp_gap = state.interp_gap - 4'h1;
      end

      // chopper sequence
      case (state.phase)
         PH_OFF:
            next_state.phase = PH_ON;
         PH_ON:
         begin
            if (state.blank != 6'h00)
               next_state.blank = state.blank - 6'h01;
            else if (coil_current_reached)
            begin
               if (chopper_mode && fast_len != 9'h000)
               begin
                  next_state.phase = PH_FAST;
                  next_state.timer = 10'(fast_len) - 10'h001;
               end
               else
               begin
                  next_state.phase = PH_SLOW;
                  next_state.timer = slow_len - 10'h001;
               end
            end
         end
         PH_FAST:
         begin
            if (state.timer == 10'h000 ||
                (!timer_only_fast_decay && coil_negative_reached))
            begin
               next_state.phase = PH_SLOW;
               next_state.timer = slow_len - 10'h001;
            end
            else
               next_state.timer = state.timer - 10'h001;
         end
         PH_SLOW:
         begin
            if (state.timer == 10'h000)
               next_state.phase = PH_ON;
            else
               next_state.timer = state.timer - 10'h001;
         end
         default:
            next_state.phase = PH_OFF;
      endcase

      // each on phase restarts blanking and hysteresis
      if (next_state.phase == PH_ON && state.phase != PH_ON)
      begin
         next_state.blank    = blank_len - 6'h01;
         next_state.hyst     = hyst_start;
         next_state.hysteresis_decrement_cnt = hysteresis_decrement_len - 7'h01;
      end
      else if (!chopper_mode && state.phase != PH_OFF)
      begin
         if (state.hysteresis_decrement_cnt == 7'h00)
         begin
            next_state.hysteresis_decrement_cnt = hysteresis_decrement_len - 7'h01;
            if (state.hyst > 5'(hysteresis_end_or_sine_offset))
               next_state.hyst = state.hyst - 5'h01;
         end
         else
            next_state.hysteresis_decrement_cnt = state.hysteresis_decrement_cnt - 7'h01;
      end

      if (off_time == 4'h0)
         next_state.phase = PH_OFF;

      if (chopper_mode)
         next_state.offset = 6'(hysteresis_end_or_sine_offset)
                             - HYST_BIAS;
      else
         next_state.offset = 6'(next_state.hyst) - HYST_BIAS;
   end

   always_ff @(posedge clock)
   begin
      if (!rst_b)
      begin
         state        <= '0;
         state.pdc    <= PULSE_DIR_RESET;
         state.chc    <= CHOPPER_RESET;
         state.cs_q   <= 1'b1;
         state.lfsr   <= LFSR_SEED;
         state.phase  <= PH_OFF;
      end
      else
         state <= next_state;
   end

   // ****************************************
   // outputs
   // ****************************************
   assign microstep_position     = state.pos;
   assign bridge_phase           = state.phase;
   assign driver_enable          = (state.phase != PH_OFF);
   assign current_offset         = state.offset;
   assign pulse_direction_config = state.pdc;
   assign chopper_config         = state.chc;

   // ****************************************
   // checks
   // ****************************************
   chk_off_disables: assert property (
      @(posedge clock) disable iff (!rst_b)
      off_time == 4'h0 |=> state.phase == PH_OFF)
      else $error("zero off-time did not switch bridges off");

   chk_blank_holds: assert property (
      @(posedge clock) disable iff (!rst_b)
      state.phase == PH_ON && state.blank != 6'h00 && off_time != 4'h0
      |=> state.phase == PH_ON)
      else $error("on phase left during blanking");

   chk_blank_load: assert property (
      @(posedge clock) disable iff (!rst_b)
      state.phase == PH_ON && $past(state.phase) != PH_ON
      |-> state.blank == $past(blank_len) - 6'h01)
      else $error("blanking count wrong at on phase start");

   chk_fast_mode: assert property (
      @(posedge clock) disable iff (!rst_b)
      state.phase == PH_FAST && $past(state.phase) == PH_ON
      |-> $past(chopper_mode) && state.timer == 10'($past(fast_len)) - 10'h001)
      else $error("fast decay entered wrongly or with wrong length");

   chk_negative_end: assert property (
      @(posedge clock) disable iff (!rst_b)
      state.phase == PH_FAST && !timer_only_fast_decay
      && coil_negative_reached && off_time != 4'h0
      |=> state.phase == PH_SLOW)
      else $error("negative current did not end fast decay");

   chk_timer_only: assert property (
      @(posedge clock) disable iff (!rst_b)
      state.phase == PH_FAST && timer_only_fast_decay
      && state.timer > 10'h001 && $stable(state.chc)
      |=> state.phase == PH_FAST)
      else $error("fast decay ended before timer");

   chk_interp_load: assert property (
      @(posedge clock) disable iff (!rst_b)
      step_event && pulse_interpolation_enable
      |=> state.interp_left == INTERP_STEPS)
      else $error("interpolation did not start 16 substeps");

   chk_falling_ignored: assert property (
      @(posedge clock) disable iff (!rst_b)
      state.step_q && !step_pulse && !double_edge_enable
      && state.interp_left == 5'h00
      |=> $stable(state.pos))
      else $error("falling edge moved position without double edge");

   chk_serial_guard: assert property (
      @(posedge clock) disable iff (!rst_b)
      serial_only_mode |=> $stable(state.pdc))
      else $error("step word written in serial-only mode");

   chk_chopper_write: assert property (
      @(posedge clock) disable iff (!rst_b)
      word_commit && state.shift[19:17] == SEL_CHOPPER
      |=> state.chc == $past(state.shift))
      else $error("chopper word not stored");

   chk_sine_offset: assert property (
      @(posedge clock) disable iff (!rst_b)
      $past(chopper_mode)
      |-> state.offset == 6'($past(hysteresis_end_or_sine_offset)) - HYST_BIAS)
      else $error("sine offset not end field minus three");

endmodule // chopper_and_step_config

/* File: tb/host_step_model.sv */
// Purpose: host serial writer and step pulse source for the bench
// Assumes: clock is the block's system clock
// Notes:   every output changes 5 ns after a rising edge

module host_step_model
   import chopper_step_pkg::*;
(
   // clock
   input  wire logic clock,
   // serial port
   output logic      spi_cs_b,
   output logic      spi_sck,
   output logic      spi_mosi,
   // step and direction
   output logic      step_pulse,
   output logic      step_direction
);
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************
   // drivers
   // ****************************************
   initial
   begin
      spi_cs_b       = 1'b1;
      spi_sck        = 1'b0;
      spi_mosi       = 1'b0;
      step_pulse     = 1'b0;
      step_direction = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #5;
   endtask

   // whole word, most significant bit first, each level held two clocks
   task automatic write_word(input logic [19:0] word);
      spi_cs_b = 1'b0;
      for (int i = WORD_W - 1; i >= 0; i--)
      begin
         spi_mosi = word[i];
         tick(2);
         spi_sck = 1'b1;
         tick(2);
         spi_sck = 1'b0;
      end
      spi_cs_b = 1'b1;
      // released data line must not keep its last value
      spi_mosi = ~spi_mosi;
      tick(3);
   endtask

   // direction set together with the edge it qualifies
   task automatic step_edge(input logic level, input logic dir);
      step_direction = dir;
      step_pulse     = level;
      tick(1);
   endtask
endmodule // host_step_model

/* File: tb/chopper_and_step_config_bench.sv */
// Purpose: self-checking bench for the step and chopper configuration
// Assumes: host_step_model drives the serial port and step input
// Notes:   phase lengths are counted at 5 ns after each rising edge

`define CHECK(what, exp, got) \
   begin \
      compares++; \
      if ((got) !== (exp)) \
      begin \
         failures++; \
         $display("wrong value %s expected %h seen %h", what, exp, got); \
      end \
   end

module chopper_and_step_config_bench import chopper_step_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;

   // ****************************************
   // signals
   // ****************************************
   logic                clock;
   logic                rst_b;
   logic                spi_cs_b;
   logic                spi_sck;
   logic                spi_mosi;
   logic                step_pulse;
   logic                step_direction;
   logic                serial_only_mode;
   logic                coil_current_reached;
   logic                coil_negative_reached;
   logic [9:0]          microstep_position;
   logic [1:0]          bridge_phase;
   logic                driver_enable;
   logic signed [5:0]   current_offset;
   logic [19:0]         pulse_direction_config;
   logic [19:0]         chopper_config;
   logic [9:0]          pos;
   int                  failures = 0;
   int                  compares = 0;
   int                  blank_clk [4] = '{16, 24, 36, 54};

   chopper_and_step_config DUT (
      .clock                  (clock),
      .rst_b                  (rst_b),
      .spi_cs_b               (spi_cs_b),
      .spi_sck                (spi_sck),
      .spi_mosi               (spi_mosi),
      .step_pulse             (step_pulse),
      .step_direction         (step_direction),
      .serial_only_mode       (serial_only_mode),
      .coil_current_reached   (coil_current_reached),
      .coil_negative_reached  (coil_negative_reached),
      .microstep_position     (microstep_position),
      .bridge_phase           (bridge_phase),
      .driver_enable          (driver_enable),
      .current_offset         (current_offset),
      .pulse_direction_config (pulse_direction_config),
      .chopper_config         (chopper_config)
   );

   host_step_model model (
      .clock          (clock),
      .spi_cs_b       (spi_cs_b),
      .spi_sck        (spi_sck),
      .spi_mosi       (spi_mosi),
      .step_pulse     (step_pulse),
      .step_direction (step_direction)
   );

   // ****************************************
   // helpers
   // ****************************************
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #5;
   endtask

   function automatic logic [19:0] step_word(input logic ip, input logic de,
                                             input logic [3:0] mr);
      return {10'h000, ip, de, 4'h0, mr};
   endfunction

   // md is mode, random, timer-only and fast msb bits
   function automatic logic [19:0] chop_word(input logic [1:0] tb,
      input logic [3:0] md, input logic [3:0] he, input logic [2:0] hs,
      input logic [3:0] tf);
      return {3'h4, tb, md, he, hs, tf};
   endfunction

   task automatic run_len(output int len);
      logic [1:0] ph;
      ph  = bridge_phase;
      len = 0;
      while (bridge_phase === ph && len < 1000)
      begin
         len++;
         tick(1);
      end
   endtask

   // driver off first, then the word, then measure on and next phase
   task automatic chop_case(input logic [19:0] w, input int on_len,
      input logic [1:0] nxt, input int lo, input int hi);
      int len;
      model.write_word(chop_word(2'h0, 4'h0, 4'h0, 3'h0, 4'h0));
      `CHECK("driver off", 1'b0, driver_enable)
      model.write_word(w);
      `CHECK("chopper word", w, chopper_config)
      `CHECK("first phase", PH_ON, bridge_phase)
      run_len(len);
      // on phase began one clock before the writer returned
      `CHECK("on length", on_len - 1, len)
      `CHECK("next phase", nxt, bridge_phase)
      run_len(len);
      `CHECK("phase length ok", 1'b1, len >= lo && len <= hi)
   endtask

   task automatic print_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ****************************************
   // clock, watchdog and tests
   // ****************************************
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   initial
   begin
      #(50 * 30000);
      failures++;
      $display("watchdog expired");
      print_verdict();
   end

   initial
   begin
      rst_b                 = 1'b0;
      serial_only_mode      = 1'b0;
      coil_current_reached  = 1'b1;
      coil_negative_reached = 1'b1;
      tick(16);
      rst_b = 1'b1;
      tick(1);
      `CHECK("reset configs", 40'h0, {pulse_direction_config, chopper_config})
      `CHECK("reset phase", 3'h0, {bridge_phase, driver_enable})
      for (int c = 0; c <= 8; c++)
      begin
         model.write_word(step_word(1'b0, 1'b0, c[3:0]));
         `CHECK("step word", step_word(1'b0, 1'b0, c[3:0]), pulse_direction_config)
         pos = microstep_position;
         model.step_edge(1'b1, 1'b0);
         model.step_edge(1'b0, 1'b0);
         tick(1);
         `CHECK("rising step", pos + (10'h001 << c), microstep_position)
      end
      model.write_word(step_word(1'b0, 1'b1, 4'h8));
      pos = microstep_position;
      model.step_edge(1'b1, 1'b0);
      model.step_edge(1'b0, 1'b0);
      tick(1);
      `CHECK("double edge", pos + 10'h200, microstep_position)
      model.step_edge(1'b1, 1'b1);
      tick(1);
      `CHECK("down step", pos + 10'h100, microstep_position)
      serial_only_mode = 1'b1;
      model.write_word(step_word(1'b0, 1'b0, 4'h0));
      model.step_edge(1'b0, 1'b0);
      tick(1);
      `CHECK("serial only", {step_word(1'b0, 1'b1, 4'h8), pos + 10'h100}, {pulse_direction_config, microstep_position})
      serial_only_mode = 1'b0;
      model.write_word(step_word(1'b1, 1'b0, 4'h4));
      pos = microstep_position;
      model.step_edge(1'b1, 1'b0);
      tick(20);
      `CHECK("interpolating", 1'b1, microstep_position - pos < 10'h010)
      tick(120);
      `CHECK("interpolated", pos + 10'h010, microstep_position)
      for (int t = 0; t < 4; t++)
         chop_case(chop_word(t[1:0], 4'h0, 4'h0, 3'h0, 4'h1), blank_clk[t], PH_SLOW, 56, 56);
      chop_case(chop_word(2'h0, 4'h0, 4'h0, 3'h0, 4'h2), 16, PH_SLOW, 88, 88);
      chop_case(chop_word(2'h0, 4'h4, 4'h0, 3'h0, 4'h1), 16, PH_SLOW, 44, 59);
      chop_case(chop_word(2'h0, 4'ha, 4'h0, 3'h1, 4'h1), 16, PH_FAST, 32, 32);
      chop_case(chop_word(2'h0, 4'hb, 4'h0, 3'h0, 4'h1), 16, PH_FAST, 256, 256);
      chop_case(chop_word(2'h0, 4'h9, 4'h0, 3'h7, 4'h1), 16, PH_FAST, 1, 2);
      model.write_word(chop_word(2'h0, 4'h8, 4'hf, 3'h0, 4'h1));
      `CHECK("sine offset high", 6'sd12, current_offset)
      model.write_word(chop_word(2'h0, 4'h8, 4'h0, 3'h0, 4'h1));
      `CHECK("sine offset low", 6'h3d, current_offset)
      coil_current_reached = 1'b0;
      model.write_word(chop_word(2'h0, 4'h0, 4'h0, 3'h0, 4'h0));
      model.write_word(chop_word(2'h0, 4'h3, 4'h5, 3'h2, 4'h1));
      tick(2);
      `CHECK("hysteresis start", 6'sd5, current_offset)
      tick(55);
      `CHECK("slow decrement", 6'sd5, current_offset)
      tick(200);
      `CHECK("hysteresis end", 6'sd2, current_offset)
      model.write_word(chop_word(2'h0, 4'h0, 4'h0, 3'h0, 4'h0));
      `CHECK("driver disabled", 3'h0, {bridge_phase, driver_enable})
      print_verdict();
   end
endmodule // chopper_and_step_config_bench
